// >>> opb_pkg.sv
// Constants for the second output path: register offsets, field positions,
// reset values and link framing figures.
// Assumes one core clock; nothing else is needed from outside.
package opb_pkg;

  // Register offsets in the channel address space
  localparam logic [7:0] OPB_PAR_CTRL_ADDR  = 8'h1a;
  localparam logic [7:0] OPB_LINK_CTRL_ADDR = 8'h1b;
  localparam logic [7:0] OPB_CLK_CTRL_ADDR  = 8'h1c;

  // Reset values
  localparam logic [7:0] OPB_PAR_CTRL_RST  = 8'h00;
  localparam logic [7:0] OPB_LINK_CTRL_RST = 8'h00;
  localparam logic [2:0] OPB_CLK_CTRL_RST  = 3'h0;

  // Parallel control fields
  localparam int OPB_PAR_SRC_BIT   = 0;
  localparam int OPB_PAR_EN_LSB    = 1;
  localparam int OPB_PAR_EN_MSB    = 4;
  localparam int OPB_PAR_FMT_BIT   = 5;

  // Link control fields
  localparam int OPB_LINK_SRC_BIT  = 0;
  localparam int OPB_LINK_MODE_BIT = 1;
  localparam int OPB_LINK_NOGAIN_BIT = 2;
  localparam int OPB_LINK_WAIT_LSB = 3;
  localparam int OPB_LINK_WAIT_MSB = 6;
  localparam int OPB_LINK_EN_BIT   = 7;

  // Port clock control fields
  localparam int OPB_CLK_MASTER_BIT = 0;
  localparam int OPB_CLK_DIV_LSB    = 1;
  localparam int OPB_CLK_DIV_MSB    = 2;

  // Link framing
  localparam logic [3:0] OPB_LINK_MIN_WAIT = 4'h6;
  localparam logic [3:0] OPB_QUAD_LAST     = 4'hf;

  // Source indices: 0..3 channels, 4 gain loop A, 5 gain loop B
  localparam int OPB_NUM_SRC = 6;
  localparam logic [2:0] OPB_SRC_LOOP_A = 3'h4;
  localparam logic [2:0] OPB_SRC_LOOP_B = 3'h5;

  typedef enum logic [1:0] {
    OPB_LINK_IDLE,
    OPB_LINK_WAIT,
    OPB_LINK_SEND
  } opb_link_state_e;

endpackage

// >>> opb_pclk_if.sv
// Interface between the output core and the port clock generator.
// Assumes both sides run on the core clock.
`timescale 1ns/100ps
interface opb_pclk_if;
  logic       master;
  logic [1:0] div;
  logic       tick;
  logic       pclk_out;

  modport gen  (input master, input div, output tick, output pclk_out);
  modport user (output master, output div, input tick, input pclk_out);
endinterface

// >>> opb_pclk_gen.sv
// Port clock generator: divides the core clock in master mode or detects
// rising edges of the external port clock in slave mode.
// Assumes the external port clock is synchronous to the core clock.
`timescale 1ns/100ps
module opb_pclk_gen
  import opb_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  // External port clock
  input  wire logic pclk_i,
  // Control and tick
  opb_pclk_if.gen   pc
);

  logic [1:0] div_cnt;
  logic       pclk_prev;
  wire        div_wrap  = (div_cnt >= pc.div);
  wire        slave_rise = pclk_i & ~pclk_prev;

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      div_cnt   <= 2'h0;
      pclk_prev <= 1'b0;
    end
    else
    begin
      div_cnt   <= div_wrap ? 2'h0 : div_cnt + 2'h1;
      pclk_prev <= pclk_i;
    end
  end

  // Master: one tick per divided period; slave: one tick per rising external edge
  assign pc.tick     = pc.master ? div_wrap : slave_rise;
  assign pc.pclk_out = (div_cnt <= (pc.div >> 1));

endmodule

// >>> opb_out_port_b.sv
// Second output path: register file, parallel port, link port and port clock.
// Assumes sample strobes and the link ready input are synchronous to the
// core clock, and the register port writes one register per strobe.
`timescale 1ns/100ps
module opb_out_port_b
  import opb_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  // Register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  // Processing channel samples
  input  wire logic [3:0]        chan_valid_i,
  input  wire logic [3:0][15:0]  chan_i_i,
  input  wire logic [3:0][15:0]  chan_q_i,
  // Gain loop samples (0 = loop A, 1 = loop B)
  input  wire logic [1:0]        loop_valid_i,
  input  wire logic [1:0][15:0]  loop_i_i,
  input  wire logic [1:0][15:0]  loop_q_i,
  input  wire logic [1:0][15:0]  loop_gain_i,
  // Parallel port
  output logic      [15:0]       par_data_o,
  output logic                   par_iq_o,
  output logic      [1:0]        par_chan_o,
  output logic                   par_valid_o,
  // Link port
  input  wire logic              link_rdy_i,
  output logic      [7:0]        link_data_o,
  output logic                   link_valid_o,
  // Port clock pin
  input  wire logic              pclk_i,
  output logic                   pclk_o,
  output logic                   pclk_oe_o
);

  //////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] par_ctrl;
  logic [7:0] link_ctrl;
  logic [2:0] clk_ctrl;

  wire wr_par  = reg_wr_i && (reg_addr_i == OPB_PAR_CTRL_ADDR);
  wire wr_link = reg_wr_i && (reg_addr_i == OPB_LINK_CTRL_ADDR);
  wire wr_clk  = reg_wr_i && (reg_addr_i == OPB_CLK_CTRL_ADDR);

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      par_ctrl  <= OPB_PAR_CTRL_RST;
      link_ctrl <= OPB_LINK_CTRL_RST;
      clk_ctrl  <= OPB_CLK_CTRL_RST;
    end
    else
    begin
      if (wr_par)
        par_ctrl <= reg_wdata_i;
      if (wr_link)
        link_ctrl <= reg_wdata_i;
      if (wr_clk)
        clk_ctrl <= reg_wdata_i[2:0];
    end
  end

  logic [7:0] next_rdata;
  always_comb
  begin
    unique case (reg_addr_i)
      OPB_PAR_CTRL_ADDR:  next_rdata = par_ctrl;
      OPB_LINK_CTRL_ADDR: next_rdata = link_ctrl;
      OPB_CLK_CTRL_ADDR:  next_rdata = {5'h00, clk_ctrl};
      default:            next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= next_rdata;
  end

  //////////////////////////////////////////////////////////////////////////
  // Port clock

  opb_pclk_if pc ();

  assign pc.master = clk_ctrl[OPB_CLK_MASTER_BIT];
  assign pc.div    = clk_ctrl[OPB_CLK_DIV_MSB:OPB_CLK_DIV_LSB];

  opb_pclk_gen u_pclk_gen (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .pclk_i    (pclk_i),
    .pc        (pc.gen)
  );

  assign pclk_o    = pc.master & pc.pclk_out;
  assign pclk_oe_o = pc.master;

  wire tick = pc.tick;

  //////////////////////////////////////////////////////////////////////////
  // Sample capture and pending flags

  wire link_en = link_ctrl[OPB_LINK_EN_BIT];
  wire par_agc = par_ctrl[OPB_PAR_SRC_BIT];
  wire par_8b  = par_ctrl[OPB_PAR_FMT_BIT];

  wire [OPB_NUM_SRC-1:0] src_valid = {loop_valid_i, chan_valid_i};
  wire [OPB_NUM_SRC-1:0] par_mask  = par_agc ?
    {par_ctrl[2:1], 4'h0} :
    {2'h0, par_ctrl[OPB_PAR_EN_MSB:OPB_PAR_EN_LSB]};

  logic [OPB_NUM_SRC-1:0][15:0] src_i;
  logic [OPB_NUM_SRC-1:0][15:0] src_q;
  logic [OPB_NUM_SRC-1:0]       pending;
  logic [OPB_NUM_SRC-1:0]       take;

  genvar gs;
  generate
    for (gs = 0; gs < OPB_NUM_SRC; gs++)
    begin : g_src
      wire [15:0] in_i = (gs < 4) ? chan_i_i[gs % 4] : loop_i_i[gs % 2];
      wire [15:0] in_q = (gs < 4) ? chan_q_i[gs % 4] : loop_q_i[gs % 2];
      wire        set  = src_valid[gs] & par_mask[gs] & ~link_en;
      always_ff @(posedge clk_sys_i)
      begin
        if (sys_rst_i)
        begin
          src_i[gs]   <= 16'h0000;
          src_q[gs]   <= 16'h0000;
          pending[gs] <= 1'b0;
        end
        else
        begin
          if (src_valid[gs])
          begin
            src_i[gs] <= in_i;
            src_q[gs] <= in_q;
          end
          pending[gs] <= set | (pending[gs] & ~take[gs] & par_mask[gs]);
        end
      end
    end
  endgenerate

  logic [1:0][15:0] gain_hold;
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      gain_hold <= '0;
    else
      for (int k = 0; k < 2; k++)
        if (loop_valid_i[k])
          gain_hold[k] <= loop_gain_i[k];
  end

  //////////////////////////////////////////////////////////////////////////
  // Parallel port

  logic       par_any;
  logic [2:0] par_sel;
  always_comb
  begin
    par_any = 1'b0;
    par_sel = 3'h0;
    for (int k = OPB_NUM_SRC - 1; k >= 0; k--)
      if (pending[k])
      begin
        par_any = 1'b1;
        par_sel = k[2:0];
      end
  end

  logic        par_q_due;
  logic [15:0] par_q_hold;
  logic [1:0]  par_chan_hold;

  wire par_start = tick & ~link_en & ~par_q_due & par_any;
  wire [1:0] sel_tag = (par_sel >= OPB_SRC_LOOP_A) ? (par_sel[1:0] - 2'h0) & 2'h1
                                                   : par_sel[1:0];

  always_comb
  begin
    take = '0;
    if (par_start)
      take[par_sel] = 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      par_data_o    <= 16'h0000;
      par_iq_o      <= 1'b0;
      par_chan_o    <= 2'h0;
      par_valid_o   <= 1'b0;
      par_q_due     <= 1'b0;
      par_q_hold    <= 16'h0000;
      par_chan_hold <= 2'h0;
    end
    else
    begin
      par_valid_o <= 1'b0;
      if (tick && par_q_due)
      begin
        par_data_o  <= par_q_hold;
        par_iq_o    <= 1'b0;
        par_chan_o  <= par_chan_hold;
        par_valid_o <= 1'b1;
        par_q_due   <= 1'b0;
      end
      else if (par_start)
      begin
        par_chan_o    <= sel_tag;
        par_chan_hold <= sel_tag;
        par_valid_o   <= 1'b1;
        par_iq_o      <= 1'b1;
        if (par_8b)
          par_data_o <= {src_i[par_sel][15:8], src_q[par_sel][15:8]};
        else
        begin
          par_data_o <= src_i[par_sel];
          par_q_hold <= src_q[par_sel];
          par_q_due  <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Link port

  opb_link_state_e link_st;
  opb_link_state_e next_link_st;
  logic [3:0] wait_cnt;
  logic [3:0] byte_cnt;

  wire link_agc    = link_ctrl[OPB_LINK_SRC_BIT];
  wire link_mode   = link_ctrl[OPB_LINK_MODE_BIT];
  wire link_nogain = link_ctrl[OPB_LINK_NOGAIN_BIT];
  wire [3:0] wait_field = link_ctrl[OPB_LINK_WAIT_MSB:OPB_LINK_WAIT_LSB];
  wire [3:0] wait_len   = (wait_field < OPB_LINK_MIN_WAIT) ? OPB_LINK_MIN_WAIT
                                                           : wait_field;
  wire [1:0] slot    = byte_cnt[3:2];
  wire [1:0] slot_b  = byte_cnt[1:0];

  logic [2:0] slot_src;
  logic       slot_gain;
  always_comb
  begin
    slot_src  = 3'h0;
    slot_gain = 1'b0;
    if (!link_agc)
      slot_src = link_mode ? {2'h0, slot[0]} : {1'b0, slot};
    else if (link_mode)
    begin
      slot_src  = OPB_SRC_LOOP_B;
      slot_gain = slot[0];
    end
    else if (link_nogain)
      slot_src = OPB_SRC_LOOP_A | {2'h0, slot[0]};
    else
    begin
      slot_src  = OPB_SRC_LOOP_A | {2'h0, slot[1]};
      slot_gain = slot[0];
    end
  end

  wire [31:0] slot_word = slot_gain ? {gain_hold[slot_src[0]], 16'h0000}
                                    : {src_i[slot_src], src_q[slot_src]};
  logic [7:0] slot_byte;
  always_comb
  begin
    unique case (slot_b)
      2'h0: slot_byte = slot_word[31:24];
      2'h1: slot_byte = slot_word[23:16];
      2'h2: slot_byte = slot_word[15:8];
      2'h3: slot_byte = slot_word[7:0];
    endcase
  end

  always_comb
  begin
    next_link_st = link_st;
    unique case (link_st)
      OPB_LINK_IDLE:
        if (link_en && link_rdy_i)
          next_link_st = OPB_LINK_WAIT;
      OPB_LINK_WAIT:
        if (!link_en)
          next_link_st = OPB_LINK_IDLE;
        else if (tick && wait_cnt >= wait_len - 4'h1)
          next_link_st = OPB_LINK_SEND;
      OPB_LINK_SEND:
        if (tick && byte_cnt == OPB_QUAD_LAST)
          next_link_st = OPB_LINK_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      link_st      <= OPB_LINK_IDLE;
      wait_cnt     <= 4'h0;
      byte_cnt     <= 4'h0;
      link_data_o  <= 8'h00;
      link_valid_o <= 1'b0;
    end
    else
    begin
      link_st      <= next_link_st;
      link_valid_o <= 1'b0;
      if (link_st != OPB_LINK_WAIT)
        wait_cnt <= 4'h0;
      else if (tick)
        wait_cnt <= wait_cnt + 4'h1;
      if (link_st != OPB_LINK_SEND)
        byte_cnt <= 4'h0;
      else if (tick)
      begin
        link_data_o  <= slot_byte;
        link_valid_o <= 1'b1;
        byte_cnt     <= byte_cnt + 4'h1;
      end
    end
  end

endmodule

// >>> opb_out_port_b_chk.sv
// Checker for the second output path, bound to its top module.
// Assumes one core clock and a synchronous active high reset.
`timescale 1ns/100ps
module opb_out_port_b_chk
(
  // Clock, reset and register port
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  // Watched outputs
  input wire logic       par_iq_o,
  input wire logic       par_valid_o,
  input wire logic       link_valid_o,
  input wire logic       pclk_o,
  input wire logic       pclk_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] par_ctl;
  logic [7:0] link_ctl;
  logic [2:0] clk_ctl;
  logic [3:0] bcnt;
  logic [7:0] gap;
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      par_ctl  <= 8'h00;
      link_ctl <= 8'h00;
      clk_ctl  <= 3'h0;
      bcnt     <= 4'h0;
      gap      <= 8'hff;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == 8'h1a) par_ctl <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 8'h1b) link_ctl <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 8'h1c) clk_ctl <= reg_wdata_i[2:0];
      if (link_valid_o) bcnt <= bcnt + 4'h1;
      gap <= link_valid_o ? 8'h00 : gap + {7'h0, gap != 8'hff};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_slave_after_reset: assert property ($past(sys_rst_i) |-> !pclk_oe_o)
    else $error("port clock driven after reset");
  a_oe_follows_mode: assert property (pclk_oe_o == clk_ctl[0])
    else $error("port clock enable wrong");
  a_slave_clock_low: assert property (!pclk_oe_o |-> !pclk_o)
    else $error("port clock out in slave mode");
  a_div_one_high: assert property (clk_ctl == 3'h1 && $past(clk_ctl) == 3'h1 |-> pclk_o)
    else $error("divide by one clock low");
  a_div_four_period: assert property ($rose(pclk_o) && clk_ctl == 3'h7
    && $past(clk_ctl) == 3'h7
    |=> (!$rose(pclk_o) || clk_ctl != 3'h7)[*3] ##1 ($rose(pclk_o) || clk_ctl != 3'h7))
    else $error("divide by four period wrong");
  a_link_owns_port: assert property (link_ctl[7] && $past(link_ctl[7], 3) |-> !par_valid_o)
    else $error("parallel word while link on");
  a_byte_flag_high: assert property (par_valid_o && par_ctl[5]
    && $past(par_ctl[5], 4) |-> par_iq_o)
    else $error("flag low in byte format");
  a_link_start_gap: assert property (link_valid_o && bcnt == 4'h0 |-> gap >= 8'h05)
    else $error("link started too early");
endmodule
bind opb_out_port_b opb_out_port_b_chk opb_out_port_b_chk_i (.clk_sys_i, .sys_rst_i,
  .reg_addr_i, .reg_wr_i, .reg_wdata_i, .par_iq_o, .par_valid_o, .link_valid_o, .pclk_o,
  .pclk_oe_o);

// >>> opb_rx_model.sv
// Receiving processor model: supplies the port clock, raises ready, keeps link bytes.
// Assumes a port clock at a quarter of the core rate, synchronous to it.
`timescale 1ns/100ps
module opb_rx_model
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // Link side
  input  wire logic       start_i,
  input  wire logic [7:0] link_data_i,
  input  wire logic       link_valid_i,
  output logic            link_rdy_o,
  output logic            pclk_o,
  output logic [4:0]      count_o
);
  logic [1:0] phase;
  logic [7:0] got [16];
  int         lat;
  assign pclk_o = phase[1];
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      phase      <= 2'h0;
      link_rdy_o <= 1'b0;
      count_o    <= 5'h0;
      lat        <= 0;
    end
    else
    begin
      phase <= phase + 2'h1;
      if (start_i)
      begin
        link_rdy_o <= 1'b1;
        count_o    <= 5'h0;
        lat        <= 0;
      end
      else if (link_rdy_o) lat <= lat + 1;
      if (link_valid_i && count_o < 5'h10)
      begin
        got[count_o[3:0]] <= link_data_i;
        count_o           <= count_o + 5'h1;
        link_rdy_o        <= 1'b0;
      end
    end
  end
endmodule

// >>> opb_out_port_b_test.sv
// Testbench for the second output path with the receiving model on its link.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
module opb_out_port_b_test;
  logic             clk_sys_i, sys_rst_i, reg_wr_i, par_iq_o, par_valid_o, link_rdy_i;
  logic             link_valid_o, pclk_i, pclk_o, pclk_oe_o, ext_clk, start;
  logic [7:0]       reg_addr_i, reg_wdata_i, reg_rdata_o, link_data_o;
  logic [3:0]       chan_valid_i;
  logic [1:0]       loop_valid_i, par_chan_o;
  logic [3:0][15:0] chan_i_i, chan_q_i;
  logic [1:0][15:0] loop_i_i, loop_q_i, loop_gain_i;
  logic [15:0]      par_data_o;
  logic [4:0]       count;
  logic [18:0]      pq [$];
  int               fail_count, comparisons, cycles;
  assign pclk_i = pclk_oe_o ? pclk_o : ext_clk;
  opb_out_port_b opb_out_port_b_i (.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_rdata_o, .chan_valid_i, .chan_i_i, .chan_q_i, .loop_valid_i, .loop_i_i, .loop_q_i,
    .loop_gain_i, .par_data_o, .par_iq_o, .par_chan_o, .par_valid_o, .link_rdy_i, .link_data_o,
    .link_valid_o, .pclk_i, .pclk_o, .pclk_oe_o);
  opb_rx_model opb_rx_model_i (.clk_sys_i, .sys_rst_i, .start_i(start), .link_data_i(link_data_o),
    .link_valid_i(link_valid_o), .link_rdy_o(link_rdy_i), .pclk_o(ext_clk), .count_o(count));
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i)
  begin
    if (par_valid_o === 1'b1) pq.push_back({par_iq_o, par_chan_o, par_data_o});
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      close_out();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task acc(input logic [7:0] a, input logic [7:0] v, input logic w);
    @(negedge clk_sys_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, v, w};
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask
  task stb;
    @(negedge clk_sys_i);
    {chan_valid_i, loop_valid_i} = 6'h3f;
    @(negedge clk_sys_i);
    {chan_valid_i, loop_valid_i} = 6'h00;
  endtask
  function automatic logic [7:0] exp_b(input logic [7:0] c, input int k);
    int          s;
    int          u;
    logic        g;
    logic [31:0] w;
    s = k / 4;
    u = c[0] ? (c[1] ? 1 : (c[2] ? s % 2 : s / 2)) : (c[1] ? s % 2 : s);
    g = c[0] && !c[2] && s % 2 == 1;
    w = !c[0] ? {16'ha0b0 + 16'(u), 16'hc0d0 + 16'(u)} :
      g ? {16'h3300 + 16'(u), 16'h0000} : {16'h1100 + 16'(u), 16'h2200 + 16'(u)};
    return w[31 - 8 * (k % 4) -: 8];
  endfunction
  task par_case(input logic [7:0] c, input int n, input logic [18:0] w0, input logic [18:0] w1);
    pq.delete();
    acc(8'h1a, c, 1'b1);
    stb();
    repeat (60) @(negedge clk_sys_i);
    chk(32'(pq.size()), 32'(n));
    chk(32'(pq[0]), 32'(w0));
    if (n > 1) chk(32'(pq[1]), 32'(w1));
  endtask
  task link_case(input logic [7:0] c);
    int n;
    pq.delete();
    acc(8'h1b, c, 1'b1);
    acc(8'h1a, 8'h1e, 1'b1);
    stb();
    @(negedge clk_sys_i) start = 1'b1;
    @(negedge clk_sys_i) start = 1'b0;
    for (n = 0; n < 600 && count != 5'h10; n++) @(negedge clk_sys_i);
    for (n = 0; n < 16; n++) chk(32'(opb_rx_model_i.got[n]), 32'(exp_b(c, n)));
    n = c[6:3] < 6 ? 6 : 32'(c[6:3]);
    n = opb_rx_model_i.lat - 4 * n;
    chk(32'(n >= 3 && n <= 6), 32'h1);
    chk(32'(pq.size()), 32'h0);
  endtask
  task master_case;
    acc(8'h1c, 8'hff, 1'b1);
    acc(8'h1c, 8'h00, 1'b0);
    chk(32'(reg_rdata_o), 32'h7);
    chk(32'(pclk_oe_o), 32'h1);
    repeat (16) @(negedge clk_sys_i);
    acc(8'h1c, 8'h01, 1'b1);
    repeat (4) @(negedge clk_sys_i);
    chk(32'(pclk_o), 32'h1);
  endtask
  task div_case(input logic [7:0] c, input int h);
    int k;
    int s;
    acc(8'h1c, c, 1'b1);
    repeat (2) @(negedge clk_sys_i);
    s = 0;
    for (k = 0; k < 12; k++)
    begin
      s += int'(pclk_o);
      @(negedge clk_sys_i);
    end
    chk(32'(s), 32'(h));
  endtask
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    {sys_rst_i, reg_wr_i, reg_addr_i, reg_wdata_i, start} = {1'b1, 18'h0};
    {chan_valid_i, loop_valid_i} = 6'h00;
    for (int c = 0; c < 4; c++) {chan_i_i[c], chan_q_i[c]} = {16'ha0b0 + 16'(c), 16'hc0d0 + 16'(c)};
    for (int l = 0; l < 2; l++) {loop_i_i[l], loop_q_i[l]} = {16'h1100 + 16'(l), 16'h2200 + 16'(l)};
    for (int l = 0; l < 2; l++) loop_gain_i[l] = 16'h3300 + 16'(l);
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i) sys_rst_i = 1'b0;
    acc(8'h1c, 8'h00, 1'b0);
    chk(32'({reg_rdata_o, pclk_oe_o}), 32'h0);
    acc(8'h1d, 8'h5a, 1'b1);
    acc(8'h1d, 8'h00, 1'b0);
    chk(32'(reg_rdata_o), 32'h0);
    par_case(8'h04, 2, {1'b1, 2'h1, 16'ha0b1}, {1'b0, 2'h1, 16'hc0d1});
    par_case(8'h23, 1, {1'b1, 2'h0, 16'h1122}, 19'h0);
    link_case(8'h80);
    link_case(8'hfa);
    link_case(8'h83);
    link_case(8'h85);
    link_case(8'h81);
    master_case();
    div_case(8'h03, 6);
    div_case(8'h05, 8);
    close_out();
  end
endmodule
